// ### design/pci_consts.svh
// constants for the port change interrupt block
`ifndef PCI_CONSTS_SVH
`define PCI_CONSTS_SVH
`define PCI_OFS_RISE     8'h00
`define PCI_OFS_FALL     8'h04
`define PCI_OFS_FLAGS    8'h08
`define PCI_OFS_CTRL     8'h0c
`define PCI_OFS_STAT     8'h10
`define PCI_OFS_MASK     8'h14
`define PCI_CTRL_MEN_BIT 0
`define PCI_CTRL_SLP_BIT 1
`define PCI_STAT_EDGE_BIT 0
`define PCI_STAT_LOST_BIT 1
`define PCI_RST_BYTE     8'h00
`define PCI_RST_CTRL     2'h0
`define PCI_RST_STAT     2'h0
`define PCI_RST_MASK     2'h0
`endif

// ### design/pci_pkg.sv
// types for the port change interrupt block
package pci_pkg;
  typedef logic [7:0] pci_byte_t;
  typedef struct packed {
    logic      cyc;
    logic      stb;
    logic      we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } pci_req_t;
  typedef enum logic [0:0] {
    PCI_IDLE = 1'b0,
    PCI_ACK  = 1'b1
  } pci_bus_state_t;
endpackage

// ### design/pci_edge_det.sv
// pin synchroniser and edge detector for eight port pins
`timescale 1ns/100ps
module pci_edge_det
  import pci_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire pci_byte_t pin_i,
  output pci_byte_t      rise_o,
  output pci_byte_t      fall_o
);
  pci_byte_t meta_reg;
  pci_byte_t sync_reg;
  pci_byte_t prev_reg;
  pci_byte_t meta_next;
  pci_byte_t sync_next;
  pci_byte_t prev_next;

  always_comb begin
    meta_next = pin_i;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // first stage is read only by the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
      prev_reg <= 8'h00;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign rise_o = sync_reg & ~prev_reg;
  assign fall_o = ~sync_reg & prev_reg;
endmodule

// ### design/pci_top.sv
// port change interrupt controller with wishbone register slave
// Notes on behaviour
// - enabled edge sets that pin's sticky flag
// - change interrupt raised only with master enable set; block interrupt is not gated by it
// - summary flag is OR of pin flags
// - writing zero clears a pin flag
// - new edge during clear keeps flag set
// - rise enable detects rising edges
// - fall enable detects falling edges
// - zero disables; enable and flag registers reset zero
// - change wakes from sleep only with enable
// - sleep edges recorded before wake completes
// - detection continues while master enable clear
// - rise and fall may be enabled together
`timescale 1ns/100ps
`include "pci_consts.svh"
module pci_top
  import pci_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  input  wire pci_byte_t   pin_i,
  output logic             summary_flag_o,
  output logic             change_irq_o,
  output logic             wake_o,
  output logic             block_irq_o
);
  pci_byte_t      rise_edge_enable;
  pci_byte_t      fall_edge_enable;
  pci_byte_t      pin_change_flags;
  logic [1:0]     ctrl_reg;
  logic [1:0]     stat_reg;
  logic [1:0]     mask_reg;
  pci_bus_state_t bus_reg;
  pci_byte_t      rise_edge_enable_next;
  pci_byte_t      fall_edge_enable_next;
  pci_byte_t      pin_change_flags_next;
  logic [1:0]     ctrl_next;
  logic [1:0]     stat_next;
  logic [1:0]     mask_next;
  pci_bus_state_t bus_next;
  logic [31:0]    dat_next;
  logic           err_next;
  logic           summary_next;
  logic           irq_next;
  logic           wake_next;
  logic           blk_next;
  logic           summary_reg;
  logic           irq_reg;
  logic           wake_reg;
  logic           blk_reg;
  pci_byte_t      rise;
  pci_byte_t      fall;
  pci_byte_t      hit;
  pci_req_t       req;
  logic           take;
  logic           wr_lane0;
  logic           ack_next;
  logic           clr_wr;

  pci_edge_det u_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (pin_i),
    .rise_o (rise),
    .fall_o (fall)
  );

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `PCI_OFS_RISE) || (a == `PCI_OFS_FALL) || (a == `PCI_OFS_FLAGS) ||
             (a == `PCI_OFS_CTRL) || (a == `PCI_OFS_STAT) || (a == `PCI_OFS_MASK);
  endfunction

  assign req      = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};
  assign take     = req.cyc && req.stb && (bus_reg == PCI_IDLE);
  assign wr_lane0 = take && req.we && req.sel[0];
  // detection runs whatever the master enable is
  assign hit      = (rise & rise_edge_enable) | (fall & fall_edge_enable);

  assign clr_wr   = wr_lane0 && (req.adr == `PCI_OFS_FLAGS);

  // bus answer: registered ack or err one cycle after the taking edge;
  // the PCI_ACK state during the answer cycle keeps a still-held request from being taken twice
  always_comb begin
    bus_next = PCI_IDLE;
    dat_next = 32'h0000_0000;
    err_next = 1'b0;
    ack_next = 1'b0;
    if (take) begin
      bus_next = PCI_ACK;
      err_next = !mapped(req.adr);
      ack_next = mapped(req.adr);
      if (!req.we) begin
        case (req.adr)
          `PCI_OFS_RISE:  dat_next = {24'h00_0000, rise_edge_enable};
          `PCI_OFS_FALL:  dat_next = {24'h00_0000, fall_edge_enable};
          `PCI_OFS_FLAGS: dat_next = {24'h00_0000, pin_change_flags};
          `PCI_OFS_CTRL:  dat_next = {30'h0000_0000, ctrl_reg};
          `PCI_OFS_STAT:  dat_next = {30'h0000_0000, stat_reg};
          `PCI_OFS_MASK:  dat_next = {30'h0000_0000, mask_reg};
          default:        dat_next = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_reg <= PCI_IDLE;
      dat_o   <= 32'h0000_0000;
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
    end else begin
      bus_reg <= bus_next;
      dat_o   <= dat_next;
      ack_o   <= ack_next;
      err_o   <= err_next;
    end
  end

  // configuration: only byte lane 0 carries register bits
  always_comb begin
    rise_edge_enable_next = rise_edge_enable;
    fall_edge_enable_next = fall_edge_enable;
    ctrl_next             = ctrl_reg;
    mask_next             = mask_reg;
    if (wr_lane0) begin
      case (req.adr)
        `PCI_OFS_RISE:  rise_edge_enable_next = req.dat[7:0];
        `PCI_OFS_FALL:  fall_edge_enable_next = req.dat[7:0];
        `PCI_OFS_CTRL:  ctrl_next = req.dat[1:0];
        `PCI_OFS_MASK:  mask_next = req.dat[1:0];
        default:        ctrl_next = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_edge_enable <= `PCI_RST_BYTE;
      fall_edge_enable <= `PCI_RST_BYTE;
      ctrl_reg         <= `PCI_RST_CTRL;
      mask_reg         <= `PCI_RST_MASK;
    end else begin
      rise_edge_enable <= rise_edge_enable_next;
      fall_edge_enable <= fall_edge_enable_next;
      ctrl_reg         <= ctrl_next;
      mask_reg         <= mask_next;
    end
  end

  // only writing zero clears; ones leave a flag as it was
  always_comb begin
    pin_change_flags_next = pin_change_flags;
    if (clr_wr) begin
      pin_change_flags_next = pin_change_flags & req.dat[7:0];
    end
    // edges set after the clear term, so the set wins
    pin_change_flags_next = pin_change_flags_next | hit;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_change_flags <= `PCI_RST_BYTE;
    end else begin
      pin_change_flags <= pin_change_flags_next;
    end
  end

  // a read of status clears it, but events of this cycle survive;
  // writes to status are ignored
  always_comb begin
    stat_next = stat_reg;
    if (take && !req.we && (req.adr == `PCI_OFS_STAT)) begin
      stat_next = `PCI_RST_STAT;
    end
    if (|hit) begin
      stat_next[`PCI_STAT_EDGE_BIT] = 1'b1;
    end
    // an edge on a flag still set means software missed one change
    if (|(hit & pin_change_flags)) begin
      stat_next[`PCI_STAT_LOST_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= `PCI_RST_STAT;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // outputs come from next-state values, so they move on the same edge as the flag
  always_comb begin
    summary_next = |pin_change_flags_next;
    irq_next     = summary_next && ctrl_next[`PCI_CTRL_MEN_BIT];
    // wake follows the recorded flag, so flags lead the core restart
    wake_next    = irq_next && ctrl_next[`PCI_CTRL_SLP_BIT];
    blk_next     = |(stat_next & mask_next);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      summary_reg <= 1'b0;
      irq_reg     <= 1'b0;
      wake_reg    <= 1'b0;
      blk_reg     <= 1'b0;
    end else begin
      summary_reg <= summary_next;
      irq_reg     <= irq_next;
      wake_reg    <= wake_next;
      blk_reg     <= blk_next;
    end
  end

  assign summary_flag_o = summary_reg;
  assign change_irq_o   = irq_reg;
  assign wake_o         = wake_reg;
  assign block_irq_o    = blk_reg;

  sequence clear_write_s;
    clr_wr;
  endsequence

  // pin change seen two edges ago, now through the synchroniser
  sequence pin_rise_s;
    $rose(pin_i[0]) ##2 rise_edge_enable[0];
  endsequence

  sequence pin_fall_s;
    $fell(pin_i[1]) ##2 fall_edge_enable[1];
  endsequence

  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    |hit |=> ((pin_change_flags & $past(hit)) == $past(hit)))
    else $error("enabled edge did not set its flag");

  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_write_s and (hit != 8'h00) |=> ((pin_change_flags & $past(hit)) == $past(hit)))
    else $error("flag lost on clear write with edge");

  zero_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_write_s and (hit == 8'h00) |=> pin_change_flags == ($past(pin_change_flags) & $past(req.dat[7:0])))
    else $error("zero write did not clear flag");

  summary_or_a: assert property (@(posedge clk_i) disable iff (rst_i)
    summary_flag_o == |pin_change_flags)
    else $error("summary flag differs from OR of flags");

  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    change_irq_o |-> ctrl_reg[`PCI_CTRL_MEN_BIT] && summary_flag_o)
    else $error("interrupt without master enable");

  no_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rise_edge_enable == 8'h00 && fall_edge_enable == 8'h00) && !clr_wr
      |=> pin_change_flags == $past(pin_change_flags))
    else $error("flag set while detection disabled");

  wake_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_o |-> change_irq_o && ctrl_reg[`PCI_CTRL_SLP_BIT])
    else $error("wake without enabled change");

  edge_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_rise_s |=> pin_change_flags[0])
    else $error("rising edge not flagged in time");

  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  fall_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_fall_s |=> pin_change_flags[1])
    else $error("falling edge not flagged in time");

  both_edges_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rise_edge_enable[2] && fall_edge_enable[2] && (rise[2] || fall[2]) |=> pin_change_flags[2])
    else $error("edge on dual enabled pin not flagged");

  master_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|hit) && !ctrl_next[`PCI_CTRL_MEN_BIT] |=> summary_flag_o && !change_irq_o)
    else $error("detection stopped or interrupt with enable clear");

  irq_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|pin_change_flags) && ctrl_reg[`PCI_CTRL_MEN_BIT] |-> change_irq_o)
    else $error("enabled interrupt missing");

  wake_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    change_irq_o && ctrl_reg[`PCI_CTRL_SLP_BIT] |-> wake_o)
    else $error("wake missing while asleep with interrupt");

  reset_zero_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> pin_change_flags == 8'h00 && rise_edge_enable == 8'h00 && fall_edge_enable == 8'h00)
    else $error("registers not zero after reset");

  ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take && mapped(req.adr) |=> ack_o && !err_o)
    else $error("mapped request not acknowledged next cycle");

  err_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take && !mapped(req.adr) |=> err_o && !ack_o)
    else $error("unmapped request not refused next cycle");

  no_retake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> !take)
    else $error("request taken during answer cycle");

  dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside answer cycle");

  block_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    block_irq_o == |(stat_reg & mask_reg))
    else $error("block interrupt differs from masked status");

  lost_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    |(hit & pin_change_flags) |=> stat_reg[`PCI_STAT_LOST_BIT])
    else $error("missed change not recorded");

  stat_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take && !req.we && (req.adr == `PCI_OFS_STAT) && (hit == 8'h00) |=> stat_reg == `PCI_RST_STAT)
    else $error("status not cleared by read");
endmodule

// ### bench/pci_pin_model.sv
// model of the external signals on the eight watched port pins
`timescale 1ns/100ps
module pci_pin_model
  import pci_pkg::*;
(
  input  wire logic      clk_i,
  input  wire pci_byte_t level_i,
  output pci_byte_t      pin_o
);
  // levels change only just after an edge, like a clean external driver
  always_ff @(posedge clk_i) begin
    pin_o <= level_i;
  end
endmodule

// ### bench/port_change_interrupt_test.sv
// self-checking testbench for the port change interrupt block
`timescale 1ns/100ps
`include "pci_consts.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module port_change_interrupt_test;
  import pci_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o;
  logic [3:0]  sel_i;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic        summary_flag_o, change_irq_o, wake_o, block_irq_o, got_err;
  pci_byte_t   pin_i, level;
  int          err_count, cmp_count, cyc_count;
  pci_pin_model u_pci_pin_model (.clk_i(clk_i), .level_i(level), .pin_o(pin_i));
  pci_top u_pci_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .pin_i(pin_i), .summary_flag_o(summary_flag_o), .change_irq_o(change_irq_o),
    .wake_o(wake_o), .block_irq_o(block_irq_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic close_out();
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one classic cycle; the answer is awaited, never assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'h1;
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o;
    got_err = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    cyc_count++;
    if (cyc_count > 3000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; sel_i = 4'h0;
    adr_i = 8'h00; dat_i = 32'h0; level = 8'h00; err_count = 0; cmp_count = 0; cyc_count = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      `CHK("reset value", 32'h0, q)
    end
    wb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped err", 1'b1, got_err)
    wb(1'b1, `PCI_OFS_RISE, 32'h05);
    wb(1'b1, `PCI_OFS_FALL, 32'h06);
    wb(1'b1, `PCI_OFS_MASK, 32'h01);
    level <= 8'h0f;
    repeat (6) @(posedge clk_i);
    wb(1'b0, `PCI_OFS_FLAGS, 32'h0);
    `CHK("flags after rise", 32'h05, q)
    `CHK("summary", 1'b1, summary_flag_o)
    `CHK("irq without enable", 1'b0, change_irq_o)
    level <= 8'h00;
    repeat (6) @(posedge clk_i);
    wb(1'b0, `PCI_OFS_FLAGS, 32'h0);
    `CHK("flags after fall", 32'h07, q)
    `CHK("block irq", 1'b1, block_irq_o)
    wb(1'b0, `PCI_OFS_STAT, 32'h0);
    `CHK("status edge", 1'b1, q[0])
    repeat (2) @(posedge clk_i);
    `CHK("block irq cleared", 1'b0, block_irq_o)
    wb(1'b1, `PCI_OFS_CTRL, 32'h03);
    repeat (2) @(posedge clk_i);
    `CHK("irq with enable", 1'b1, change_irq_o)
    `CHK("wake", 1'b1, wake_o)
    // clear only the known bit by masking, the others stay
    wb(1'b1, `PCI_OFS_FLAGS, 32'hfe);
    wb(1'b0, `PCI_OFS_FLAGS, 32'h0);
    `CHK("flags masked clear", 32'h06, q)
    wb(1'b1, `PCI_OFS_FLAGS, 32'h00);
    repeat (2) @(posedge clk_i);
    `CHK("summary cleared", 1'b0, summary_flag_o)
    `CHK("irq cleared", 1'b0, change_irq_o)
    `CHK("wake cleared", 1'b0, wake_o)
    // the pin rises so that its edge reaches the flags at the clearing write's edge
    wb(1'b1, `PCI_OFS_RISE, 32'h10);
    level <= 8'h10;
    repeat (2) @(posedge clk_i);
    wb(1'b1, `PCI_OFS_FLAGS, 32'h00);
    wb(1'b0, `PCI_OFS_FLAGS, 32'h0);
    `CHK("flag kept on clear", 32'h10, q)
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `PCI_OFS_FLAGS, 32'h0);
    `CHK("flags after reset", 32'h0, q)
    wb(1'b0, `PCI_OFS_RISE, 32'h0);
    `CHK("rise after reset", 32'h0, q)
    close_out();
  end
endmodule
